// [design/lps_pkg.sv]
package lps_pkg;
   // Clock and timing
   localparam int unsigned CLK_MHZ = 100;
   localparam real STEP_MS = 2.72;
   localparam int unsigned STEP_CYC = int'(STEP_MS * 1000.0 * CLK_MHZ) - 0;
   localparam real PULSE_ON_US = 7.3;
   localparam int unsigned PULSE_ON_CYC = int'(PULSE_ON_US * CLK_MHZ);
   localparam int unsigned PULSE_PER_US = 16;
   localparam int unsigned PULSE_PER_CYC = PULSE_PER_US * CLK_MHZ;
   localparam int unsigned LONG_WAIT_MULT = 12;
   localparam int unsigned STEP_COUNTS_MAX = 1023;
   localparam int unsigned TIME_BASE = 256;
   // Control bit position of power-on in control register 0
   localparam int unsigned CTRL_ADDR = 0;
   localparam int unsigned POWER_ON_POS = 0;
   // Sink current in tenths of mA per drive setting
   localparam logic [9:0] SINK_0 = 10'h3e8;
   localparam logic [9:0] SINK_1 = 10'h1f4;
   localparam logic [9:0] SINK_2 = 10'h0fa;
   localparam logic [9:0] SINK_3 = 10'h07d;

   typedef enum logic [2:0] {
      ST_SLEEP, ST_PON_DLY, ST_START, ST_PROX_PULSE, ST_PROX_CONV, ST_WAIT, ST_LIGHT
   } seq_state_t;

   typedef struct packed {
      logic power_on_bit;
      logic prox_enable_bit;
      logic wait_enable_bit;
      logic light_enable_bit;
      logic long_wait_bit;
      logic [7:0] prox_conv_time;
      logic [7:0] wait_time_field;
      logic [7:0] light_integ_time;
      logic [1:0] led_current_sel;
      logic [7:0] led_pulse_number;
   } cfg_t;

   typedef struct packed {
      logic [15:0] visible_ir_channel;
      logic [15:0] ir_only_channel;
   } light_data_t;
endpackage

// [design/step_timer.sv]
`timescale 1ns/10ps
// Counts 2.72 ms steps; done pulses after the requested number of steps
module step_timer (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Control
   input wire logic start_i,
   input wire logic [12:0] steps_i,
   // Status
   output logic step_o,
   output logic done_o
);
   logic [18:0] cyc_q, cyc_d;
   logic [12:0] left_q, left_d;
   logic run_q, run_d;

   // Next-state of the step divider and step counter
   always_comb begin
      cyc_d = cyc_q;
      left_d = left_q;
      run_d = run_q;
      step_o = 1'b0;
      done_o = 1'b0;
      if (start_i) begin
         run_d = 1'b1;
         cyc_d = '0;
         left_d = steps_i;
      end else if (run_q) begin
         if (cyc_q == 19'(lps_pkg::STEP_CYC - 1)) begin
            cyc_d = '0;
            step_o = 1'b1;
            left_d = left_q - 13'h1;
            if (left_q == 13'h1) begin
               run_d = 1'b0;
               done_o = 1'b1;
            end
         end else begin
            cyc_d = cyc_q + 19'h1;
         end
      end
   end

   // Registers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cyc_q <= '0;
         left_q <= '0;
         run_q <= 1'b0;
      end else begin
         cyc_q <= cyc_d;
         left_q <= left_d;
         run_q <= run_d;
      end
   end
endmodule

// [design/light_prox_sequencer.sv]
`timescale 1ns/10ps
// Contract
// - Reset enters sleep, no measuring
// - Power-on bit leaves sleep toward start
// - Order is proximity, wait, ambient light
// - Disabled phases are skipped
// - Clearing power-on finishes conversions, then sleeps
// - Power-on bit is register 0 bit 0
// - Proximity steps 2.72 ms, max 1023 counts
// - Proximity conversion 1 to 256 steps
// - LED on 7.3 us, period 16 us
// - Drive select gives 100/50/25/12.5 mA
// - Wait counts 1 to 256 steps
// - Two channels integrate simultaneously
// - One 2.72 ms delay before start
// - Long wait multiplies wait by twelve
// - Time equals 2.72 ms times (256-field)
// - Up to 255 LED pulses per phase
module light_prox_sequencer (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Configuration and control
   input wire lps_pkg::cfg_t cfg_i,
   // Analog front-end comparator pulses (one per count)
   input wire logic prox_count_i,
   input wire logic visible_ir_count_i,
   input wire logic ir_only_count_i,
   // LED sink
   output logic led_sink_pin_o,
   output logic [9:0] led_sink_ma10_o,
   // Results
   output logic [15:0] prox_data_o,
   output lps_pkg::light_data_t light_data_o,
   output logic prox_valid_o,
   output logic light_valid_o,
   // Status
   output lps_pkg::seq_state_t state_o,
   output logic active_o
);
   lps_pkg::seq_state_t st_q, st_d;
   logic tmr_start;
   logic [12:0] tmr_steps;
   logic tmr_step, tmr_done;
   logic [10:0] pcyc_q, pcyc_d;
   logic [7:0] pulses_q, pulses_d;
   logic led_q, led_d;
   logic [15:0] pacc_q, pacc_d;
   logic [9:0] pstep_q, pstep_d;
   logic [15:0] c0_q, c0_d, c1_q, c1_d;
   logic [15:0] pout_q, pout_d;
   lps_pkg::light_data_t lout_q, lout_d;
   logic pv_q, pv_d, lv_q, lv_d;
   logic [9:0] sink_q, sink_d;

   // Step count from two's-complement field, optionally times twelve
   function automatic logic [12:0] steps_of(input logic [7:0] f, input logic mult12);
      logic [12:0] n;
      n = 13'(lps_pkg::TIME_BASE) - {5'h0, f};
      steps_of = mult12 ? 13'(n * 13'(lps_pkg::LONG_WAIT_MULT)) : n;
   endfunction

   // Drive select to sink current
   function automatic logic [9:0] sink_of(input logic [1:0] s);
      case (s)
         2'h0: sink_of = lps_pkg::SINK_0;
         2'h1: sink_of = lps_pkg::SINK_1;
         2'h2: sink_of = lps_pkg::SINK_2;
         default: sink_of = lps_pkg::SINK_3;
      endcase
   endfunction

   step_timer u_timer (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .start_i(tmr_start),
      .steps_i(tmr_steps),
      .step_o(tmr_step),
      .done_o(tmr_done)
   );

   // Phase choice after start, in fixed order
   function automatic lps_pkg::seq_state_t after_start(input lps_pkg::cfg_t c);
      if (c.prox_enable_bit) after_start = lps_pkg::ST_PROX_PULSE;
      else if (c.wait_enable_bit) after_start = lps_pkg::ST_WAIT;
      else if (c.light_enable_bit) after_start = lps_pkg::ST_LIGHT;
      else after_start = lps_pkg::ST_START;
   endfunction

   // Sequencer next state and datapath
   always_comb begin
      st_d = st_q;
      tmr_start = 1'b0;
      tmr_steps = 13'h1;
      pcyc_d = pcyc_q;
      pulses_d = pulses_q;
      led_d = 1'b0;
      pacc_d = pacc_q;
      pstep_d = pstep_q;
      c0_d = c0_q;
      c1_d = c1_q;
      pout_d = pout_q;
      lout_d = lout_q;
      pv_d = 1'b0;
      lv_d = 1'b0;
      sink_d = sink_of(cfg_i.led_current_sel);
      case (st_q)
         lps_pkg::ST_SLEEP: begin
            if (cfg_i.power_on_bit) begin
               st_d = lps_pkg::ST_PON_DLY;
               tmr_start = 1'b1;
               tmr_steps = 13'h1;
            end
         end
         lps_pkg::ST_PON_DLY: begin
            if (tmr_done) st_d = lps_pkg::ST_START;
         end
         lps_pkg::ST_START: begin
            if (!cfg_i.power_on_bit) begin
               st_d = lps_pkg::ST_SLEEP;
            end else begin
               st_d = after_start(cfg_i);
               pcyc_d = '0;
               pulses_d = '0;
               pacc_d = '0;
               c0_d = '0;
               c1_d = '0;
               if (!cfg_i.prox_enable_bit && cfg_i.wait_enable_bit) begin
                  tmr_start = 1'b1;
                  tmr_steps = steps_of(cfg_i.wait_time_field, cfg_i.long_wait_bit);
               end else if (!cfg_i.prox_enable_bit && cfg_i.light_enable_bit) begin
                  tmr_start = 1'b1;
                  tmr_steps = steps_of(cfg_i.light_integ_time, 1'b0);
               end
            end
         end
         lps_pkg::ST_PROX_PULSE: begin
            if (pulses_q >= cfg_i.led_pulse_number) begin
               st_d = lps_pkg::ST_PROX_CONV;
               tmr_start = 1'b1;
               tmr_steps = steps_of(cfg_i.prox_conv_time, 1'b0);
               pstep_d = '0;
            end else begin
               led_d = pcyc_q < 11'(lps_pkg::PULSE_ON_CYC);
               if (pcyc_q == 11'(lps_pkg::PULSE_PER_CYC - 1)) begin
                  pcyc_d = '0;
                  pulses_d = pulses_q + 8'h1;
               end else begin
                  pcyc_d = pcyc_q + 11'h1;
               end
            end
         end
         lps_pkg::ST_PROX_CONV: begin
            if (prox_count_i && pstep_q < 10'(lps_pkg::STEP_COUNTS_MAX)) begin
               pstep_d = pstep_q + 10'h1;
               pacc_d = pacc_q + 16'h1;
            end
            if (tmr_step) pstep_d = '0;
            if (tmr_done) begin
               pout_d = pacc_d;
               pv_d = 1'b1;
               if (cfg_i.wait_enable_bit) begin
                  st_d = lps_pkg::ST_WAIT;
                  tmr_start = 1'b1;
                  tmr_steps = steps_of(cfg_i.wait_time_field, cfg_i.long_wait_bit);
               end else if (cfg_i.light_enable_bit) begin
                  st_d = lps_pkg::ST_LIGHT;
                  tmr_start = 1'b1;
                  tmr_steps = steps_of(cfg_i.light_integ_time, 1'b0);
               end else begin
                  st_d = lps_pkg::ST_START;
               end
            end
         end
         lps_pkg::ST_WAIT: begin
            if (tmr_done) begin
               if (cfg_i.light_enable_bit) begin
                  st_d = lps_pkg::ST_LIGHT;
                  tmr_start = 1'b1;
                  tmr_steps = steps_of(cfg_i.light_integ_time, 1'b0);
               end else begin
                  st_d = lps_pkg::ST_START;
               end
            end
         end
         lps_pkg::ST_LIGHT: begin
            // Both channels accumulate in the same window
            if (visible_ir_count_i && c0_q != 16'hffff) c0_d = c0_q + 16'h1;
            if (ir_only_count_i && c1_q != 16'hffff) c1_d = c1_q + 16'h1;
            if (tmr_done) begin
               lout_d.visible_ir_channel = c0_d;
               lout_d.ir_only_channel = c1_d;
               lv_d = 1'b1;
               st_d = lps_pkg::ST_START;
            end
         end
         default: st_d = lps_pkg::ST_SLEEP;
      endcase
   end

   // Registers
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st_q <= lps_pkg::ST_SLEEP;
         pcyc_q <= '0;
         pulses_q <= '0;
         led_q <= 1'b0;
         pacc_q <= '0;
         pstep_q <= '0;
         c0_q <= '0;
         c1_q <= '0;
         pout_q <= '0;
         lout_q <= '0;
         pv_q <= 1'b0;
         lv_q <= 1'b0;
         sink_q <= lps_pkg::SINK_0;
      end else begin
         st_q <= st_d;
         pcyc_q <= pcyc_d;
         pulses_q <= pulses_d;
         led_q <= led_d;
         pacc_q <= pacc_d;
         pstep_q <= pstep_d;
         c0_q <= c0_d;
         c1_q <= c1_d;
         pout_q <= pout_d;
         lout_q <= lout_d;
         pv_q <= pv_d;
         lv_q <= lv_d;
         sink_q <= sink_d;
      end
   end

   // Outputs
   assign led_sink_pin_o = led_q;
   assign led_sink_ma10_o = sink_q;
   assign prox_data_o = pout_q;
   assign light_data_o = lout_q;
   assign prox_valid_o = pv_q;
   assign light_valid_o = lv_q;
   assign state_o = st_q;
   assign active_o = (st_q != lps_pkg::ST_SLEEP);
endmodule

// [testbench/lps_props.sv]
`timescale 1ns/10ps
module lps_props (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Watched ports
   input wire lps_pkg::cfg_t cfg_i,
   input wire logic led_sink_pin_o,
   input wire logic [9:0] led_sink_ma10_o,
   input wire lps_pkg::seq_state_t state_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   int unsigned on_q = 0;
   int unsigned per_q = 0;
   int unsigned dly_q = 0;
   // Length of the lit span, spacing of rises, time spent in power-up delay
   always_ff @(posedge sys_clk_i) begin
      on_q <= led_sink_pin_o ? on_q + 1 : 0;
      per_q <= (led_sink_pin_o && on_q == 0) ? 1 : per_q + 1;
      dly_q <= (state_o == lps_pkg::ST_PON_DLY) ? dly_q + 1 : 0;
   end
   sequence s_pon_req;
      state_o == lps_pkg::ST_SLEEP && cfg_i.power_on_bit;
   endsequence
   sequence s_dly_end;
      $past(state_o) == lps_pkg::ST_PON_DLY && state_o != lps_pkg::ST_PON_DLY;
   endsequence
   a_release_sleep: assert property ($rose(resetn_i) |-> state_o == lps_pkg::ST_SLEEP)
      else $error("not asleep after reset");
   a_sleep_dark: assert property (state_o == lps_pkg::ST_SLEEP |-> !led_sink_pin_o)
      else $error("led lit in sleep");
   a_wake_up: assert property (s_pon_req |=> state_o == lps_pkg::ST_PON_DLY)
      else $error("power-on ignored");
   a_pon_delay: assert property (s_dly_end |-> dly_q >= lps_pkg::STEP_CYC - 2 && dly_q <= lps_pkg::STEP_CYC + 3)
      else $error("power-up delay wrong");
   a_prox_order: assert property ($past(state_o) == lps_pkg::ST_PROX_PULSE
      && state_o != lps_pkg::ST_PROX_PULSE |-> state_o == lps_pkg::ST_PROX_CONV)
      else $error("proximity order broken");
   a_led_phase: assert property (led_sink_pin_o |-> state_o == lps_pkg::ST_PROX_PULSE)
      else $error("led outside pulse phase");
   a_pulse_width: assert property ($fell(led_sink_pin_o) |-> on_q == lps_pkg::PULSE_ON_CYC)
      else $error("led on time wrong");
   a_pulse_period: assert property ($rose(led_sink_pin_o) && per_q < 3200
      |-> per_q == lps_pkg::PULSE_PER_CYC)
      else $error("led period wrong");
   a_sink_map: assert property ($past(resetn_i)
      |-> led_sink_ma10_o == (10'h3e8 >> $past(cfg_i.led_current_sel)))
      else $error("sink current wrong");
endmodule
bind light_prox_sequencer lps_props chk_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .cfg_i(cfg_i), .led_sink_pin_o(led_sink_pin_o), .led_sink_ma10_o(led_sink_ma10_o),
   .state_o(state_o));

// [testbench/ir_led_model.sv]
`timescale 1ns/10ps
// Emitter seen through a reflector: one count every fourth lit cycle
module ir_led_model (
   input wire logic sys_clk_i,
   input wire logic lit_i,
   input wire logic [9:0] ma10_i,
   output logic echo_o
);
   logic [1:0] ph_q = 2'h0;
   initial echo_o = 1'b0;
   // No drive current means no reflection
   always @(posedge sys_clk_i) begin
      ph_q <= lit_i ? ph_q + 2'h1 : 2'h0;
      echo_o <= lit_i && ph_q == 2'h3 && ma10_i != 10'h000;
   end
endmodule

// [testbench/tb_light_prox_sequencer.sv]
`timescale 1ns/10ps
module tb_light_prox_sequencer;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   lps_pkg::cfg_t cfg_i = '0;
   logic echo, vis = 1'b0, iro = 1'b0, led;
   logic [9:0] ma, ma_l = 10'h3e8;
   lps_pkg::seq_state_t st;
   int fails = 0, samples_checked = 0, seed = 32'ha64b, n, k;
   int unsigned on_c = 0;
   logic [31:0] ma_q[$], pw_q[$];
   always #5 sys_clk_i = ~sys_clk_i;
   light_prox_sequencer dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_i(cfg_i),
      .prox_count_i(echo), .visible_ir_count_i(vis), .ir_only_count_i(iro),
      .led_sink_pin_o(led), .led_sink_ma10_o(ma), .prox_data_o(), .light_data_o(),
      .prox_valid_o(), .light_valid_o(), .state_o(st), .active_o());
   ir_led_model led_u (.sys_clk_i(sys_clk_i), .lit_i(led), .ma10_i(ma), .echo_o(echo));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Retires the oldest note when a pulse ends or the sink current moves
   always @(posedge sys_clk_i) begin
      on_c <= led ? on_c + 1 : 0;
      if (!led && on_c != 0) chk("pulse", pw_q.size() ? pw_q.pop_front() : 0, on_c);
      if (!resetn_i) ma_l <= ma;
      else if (ma !== ma_l) begin
         chk("sink", ma_q.size() ? ma_q.pop_front() : 0, ma);
         ma_l <= ma;
      end
   end
   // Watchdog
   initial begin
      repeat (320000) @(posedge sys_clk_i);
      fails++;
      final_report();
   end
   initial begin
      repeat (16) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk("state", lps_pkg::ST_SLEEP, st);
      // Every drive code, then random codes and light counts
      for (int i = 0; i < 12; i++) begin
         n = (i < 4) ? i : $random(seed);
         if (n[1:0] != cfg_i.led_current_sel) ma_q.push_back(32'h3e8 >> n[1:0]);
         cfg_i.led_current_sel = n[1:0];
         vis = n[2];
         iro = n[3];
         repeat (3) @(negedge sys_clk_i);
      end
      chk("led", 0, led);
      // Power up with only proximity enabled and a short train
      n = 2 + {$random(seed)} % 3;
      cfg_i.led_pulse_number = n[7:0];
      cfg_i.prox_enable_bit = 1'b1;
      cfg_i.prox_conv_time = 8'hff;
      cfg_i.power_on_bit = 1'b1;
      for (int i = 0; i < n; i++) pw_q.push_back(lps_pkg::PULSE_ON_CYC);
      @(negedge sys_clk_i);
      chk("state", lps_pkg::ST_PON_DLY, st);
      for (k = 1; k < 280000 && st === lps_pkg::ST_PON_DLY; k++) @(negedge sys_clk_i);
      chk("delay", 1, k + 3 >= lps_pkg::STEP_CYC && k <= lps_pkg::STEP_CYC + 3);
      for (k = 0; k < 8 && st !== lps_pkg::ST_PROX_PULSE; k++) @(negedge sys_clk_i);
      chk("state", lps_pkg::ST_PROX_PULSE, st);
      // Power-off mid-train must not abort the conversion
      repeat (200) @(negedge sys_clk_i);
      cfg_i.power_on_bit = 1'b0;
      for (k = 0; k < 7000 && st === lps_pkg::ST_PROX_PULSE; k++) @(negedge sys_clk_i);
      repeat (1000) @(negedge sys_clk_i);
      chk("state", lps_pkg::ST_PROX_CONV, st);
      chk("pulses", 0, pw_q.size() + ma_q.size());
      // Reset puts the sink back to full current, then it follows the select again
      if (cfg_i.led_current_sel != 2'h0) ma_q.push_back(32'h3e8 >> cfg_i.led_current_sel);
      resetn_i = 1'b0;
      repeat (16) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      chk("state", lps_pkg::ST_SLEEP, st);
      final_report();
   end
endmodule
